// ### design/crx_map.vh
/*
 receive buffer logic register map: byte offsets of the words, field positions, reset values.
 assumes a 32-bit classic wishbone slave with word-aligned byte addresses.
*/
`ifndef CRX_MAP_VH
`define CRX_MAP_VH
`define CRX_ADDR_W        8
`define CRX_OFF_CFG       8'h00
`define CRX_OFF_STATUS    8'h04
`define CRX_OFF_B0CTL     8'h08
`define CRX_OFF_B1CTL     8'h0C
`define CRX_OFF_B0ID      8'h10
`define CRX_OFF_B1ID      8'h14
`define CRX_OFF_B0DLO     8'h18
`define CRX_OFF_B0DHI     8'h1C
`define CRX_OFF_B1DLO     8'h20
`define CRX_OFF_B1DHI     8'h24
`define CRX_OFF_FEXT      8'h28
`define CRX_OFF_FASSIGN   8'h2C
`define CRX_OFF_FASSIGN2  8'h30
`define CRX_OFF_TXCFG     8'h34
`define CRX_OFF_EMPTY_RD  32'h0000_0000
// cfg fields
`define CRX_CFG_OPMODE_LO 0
`define CRX_CFG_OPMODE_HI 1
`define CRX_CFG_RIE       2
`define CRX_CFG_ROLL      3
`define CRX_CFG_RXM0_LO   4
`define CRX_CFG_RXM0_HI   5
`define CRX_CFG_RECEIVE_ALL_BIT_LO   6
`define CRX_CFG_RECEIVE_ALL_BIT_HI   7
`define CRX_CFG_MEXT0     8
`define CRX_CFG_MEXT1     9
`define CRX_CFG_MIDE0     10
`define CRX_CFG_MIDE1     11
`define CRX_CFG_RST       32'h0000_0000
// buffer control fields
`define CRX_CTL_FULL      0
`define CRX_CTL_RTR       1
`define CRX_CTL_EXT       2
`define CRX_CTL_HIT_LO    8
`define CRX_CTL_HIT_HI    12
`define CRX_CTL_DLC_LO    16
`define CRX_CTL_DLC_HI    19
`define CRX_NFILT         16
`define CRX_MAXDLC        4'h8
`endif

// ### design/crx_rx_buffers.v
/*
 can receive buffer management: moves each assembled frame into one of two
 receive buffers, with acceptance, receive modes, priority and rollover.
 assumes the protocol engine presents a finished (or error-cut) frame as a
 one-cycle pulse with identifier, length, data and per-filter match vector.
*/
// Functional notes
// - assembly buffer always takes next frame
// - transfer into buffer sets full flag
// - full buffer is never overwritten
// - receive enable raises interrupt per load
// - record filter hit index per mode
// - control shows remote or data frame
// - store extended flag and identifier bytes
// - store length code and data bytes
// - mode 00 accepts by filters
// - mode 0: 01 standard, 10 extended
// - conflicting filter never accepts
// - modes 1/2: mask type bit restricts
// - receive-all mode ignores filters
// - receive-all copies error-cut frames
// - filters on transmit buffers discard frames
// - buffer 0 two filters, buffer 1 four
// - rollover moves into buffer 1
// - mode 0 one mask per buffer
// - modes 1/2 sixteen assignable filters
// - lowest-numbered accepting buffer wins
`timescale 1ns/1ns
`default_nettype none
`include "crx_map.vh"
module crx_rx_buffers
(
  // clock and reset
  input  wire                   i_clk,
  input  wire                   i_sys_rst,
  // wishbone slave
  input  wire                   i_wb_cyc,
  input  wire                   i_wb_stb,
  input  wire                   i_wb_we,
  input  wire [`CRX_ADDR_W-1:0] i_wb_adr,
  input  wire [3:0]             i_wb_sel,
  input  wire [31:0]            i_wb_dat,
  output reg  [31:0]            o_wb_dat,
  output reg                    o_wb_ack,
  // message assembly buffer from protocol engine
  input  wire                   i_frame_done,
  input  wire                   i_frame_err,
  input  wire                   i_frame_ext,
  input  wire                   i_frame_rtr,
  input  wire [28:0]            i_frame_id,
  input  wire [3:0]             i_frame_dlc,
  input  wire [63:0]            i_frame_data,
  input  wire [15:0]            i_filter_match,
  // status
  output reg                    o_rx_irq,
  output reg                    o_rx_overflow
);

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  reg  [31:0] cfg_reg;
  reg  [15:0] fext_reg;       // filter_extended_select per filter
  reg  [15:0] fassign_reg;    // modes 1/2: filter i targets buffer bit i
  reg  [15:0] fassign2_reg;   // modes 1/2: filter i enabled
  reg  [1:0]  txcfg_reg;      // programmable buffer configured for transmit
  reg  [1:0]  full_reg;
  reg  [1:0]  rtr_reg;
  reg  [1:0]  ext_reg;
  reg  [4:0]  hit_reg [0:1];
  reg  [3:0]  dlc_reg [0:1];
  reg  [28:0] id_reg  [0:1];
  reg  [63:0] data_reg[0:1];
  reg         ovf_reg;

  wire [1:0] opmode = cfg_reg[`CRX_CFG_OPMODE_HI:`CRX_CFG_OPMODE_LO];
  wire       mode0  = (opmode == 2'h0);
  wire [1:0] rxm0   = cfg_reg[`CRX_CFG_RXM0_HI:`CRX_CFG_RXM0_LO];
  wire [1:0] receive_all_bit   = cfg_reg[`CRX_CFG_RECEIVE_ALL_BIT_HI:`CRX_CFG_RECEIVE_ALL_BIT_LO];

  // --------------------------------------------------------------
  // acceptance per buffer
  // --------------------------------------------------------------
  reg  [1:0] accept;
  reg  [1:0] all_mode;
  reg  [4:0] hit_idx [0:1];
  reg        discard;
  reg  [1:0] receive_mode_select;
  reg        type_ok;
  integer    b;
  integer    f;
  always @*
  begin
    discard = 1'b0;
    receive_mode_select     = 2'h0;
    type_ok = 1'b0;
    for (b = 0; b < 2; b = b + 1)
    begin
      accept[b]   = 1'b0;
      hit_idx[b]  = 5'h00;
      receive_mode_select         = (b == 0) ? rxm0 : receive_all_bit;
      if (mode0)
        all_mode[b] = (receive_mode_select == 2'h3);
      else
        all_mode[b] = receive_mode_select[1];
      // in modes 1/2 the mask type bit with rxm[0] restricts type
      if (mode0)
        type_ok = (receive_mode_select == 2'h0) || (receive_mode_select == 2'h1 && !i_frame_ext) ||
                  (receive_mode_select == 2'h2 && i_frame_ext);
      else
        type_ok = !receive_mode_select[0] ||
                  (cfg_reg[`CRX_CFG_MIDE0 + b] == i_frame_ext);
      if (all_mode[b])
        accept[b] = !txcfg_reg[b] || mode0;
      else if (type_ok)
      begin
        // scan high to low so the lowest matching filter is recorded
        for (f = `CRX_NFILT - 1; f >= 0; f = f - 1)
        begin
          if (i_filter_match[f] && (fext_reg[f] == i_frame_ext))
          begin
            if (mode0 && ((b == 0 && f < 2) || (b == 1 && f >= 2 && f < 6)))
            begin
              accept[b]  = 1'b1;
              hit_idx[b] = f[4:0];
            end
            else if (!mode0 && fassign2_reg[f] && (fassign_reg[f] == b[0]))
            begin
              if (txcfg_reg[b])
                discard = 1'b1;
              else
              begin
                accept[b]  = 1'b1;
                hit_idx[b] = f[4:0];
              end
            end
          end
        end
      end
    end
  end

  // error-cut frames only count where the buffer runs receive-all
  wire [1:0] acc_ok = i_frame_err ? (accept & all_mode) : accept;
  wire       take   = i_frame_done && !discard;
  reg  [1:0] load;
  reg        ovf_evt;
  always @*
  begin
    load    = 2'b00;
    ovf_evt = 1'b0;
    if (take)
    begin
      if (acc_ok[0] && !full_reg[0])
        load = 2'b01;
      else if (acc_ok[0] && mode0 && cfg_reg[`CRX_CFG_ROLL] && !full_reg[1])
        load = 2'b10;
      else if (acc_ok[1] && !full_reg[1])
        load = 2'b10;
      else if (acc_ok != 2'b00)
        ovf_evt = 1'b1;
    end
  end

  // --------------------------------------------------------------
  // wishbone access
  // --------------------------------------------------------------
  wire       wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire       wb_wr  = wb_req && i_wb_we && i_wb_sel[0];
  reg  [31:0] rd_next;

  // --------------------------------------------------------------
  // buffer control words as software sees them
  // --------------------------------------------------------------
  wire [31:0] ctl_word0 = {12'h0, dlc_reg[0], 3'h0, hit_reg[0], 5'h0, ext_reg[0],
                           rtr_reg[0], full_reg[0]};
  wire [31:0] ctl_word1 = {12'h0, dlc_reg[1], 3'h0, hit_reg[1], 5'h0, ext_reg[1],
                           rtr_reg[1], full_reg[1]};

  always @*
  begin
    case (i_wb_adr)
      `CRX_OFF_CFG:      rd_next = cfg_reg;
      `CRX_OFF_STATUS:   rd_next = {29'h0, ovf_reg, full_reg};
      `CRX_OFF_B0CTL:    rd_next = ctl_word0;
      `CRX_OFF_B1CTL:    rd_next = ctl_word1;
      `CRX_OFF_B0ID:     rd_next = {3'h0, id_reg[0]};
      `CRX_OFF_B1ID:     rd_next = {3'h0, id_reg[1]};
      `CRX_OFF_B0DLO:    rd_next = data_reg[0][31:0];
      `CRX_OFF_B0DHI:    rd_next = data_reg[0][63:32];
      `CRX_OFF_B1DLO:    rd_next = data_reg[1][31:0];
      `CRX_OFF_B1DHI:    rd_next = data_reg[1][63:32];
      `CRX_OFF_FEXT:     rd_next = {16'h0, fext_reg};
      `CRX_OFF_FASSIGN:  rd_next = {16'h0, fassign_reg};
      `CRX_OFF_FASSIGN2: rd_next = {16'h0, fassign2_reg};
      `CRX_OFF_TXCFG:    rd_next = {30'h0, txcfg_reg};
      default:           rd_next = `CRX_OFF_EMPTY_RD;
    endcase
  end

  // --------------------------------------------------------------
  // state update
  // --------------------------------------------------------------
  integer k;

  // --------------------------------------------------------------
  // status clear strobes
  // --------------------------------------------------------------
  // write one to clear; an event in the same cycle wins, so a frame that
  // lands while software clears is never lost
  wire       st_wr    = wb_wr && (i_wb_adr == `CRX_OFF_STATUS);
  wire [1:0] full_clr = {2{st_wr}} & i_wb_dat[1:0];
  wire       ovf_clr  = st_wr && i_wb_dat[2];

  // --------------------------------------------------------------
  // capture from the assembly buffer
  // --------------------------------------------------------------
  // standard frames keep only the 11-bit identifier, so bits left over
  // from an earlier extended frame never reach software
  wire [28:0] id_store   = i_frame_ext ? i_frame_id : {18'h0, i_frame_id[10:0]};
  // mode 0 has six filters, so three index bits are enough there
  wire [4:0]  hit_store0 = mode0 ? {2'b00, hit_idx[0][2:0]} : hit_idx[0];
  wire [4:0]  hit_store1 = mode0 ? {2'b00, hit_idx[1][2:0]} : hit_idx[1];

  // --------------------------------------------------------------
  // bus response
  // --------------------------------------------------------------
  // ack follows one cycle after the request and drops again, so a master
  // that holds stb through the ack edge is not answered twice
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= wb_req;
      if (wb_req)
        o_wb_dat <= rd_next;
    end
  end

  // --------------------------------------------------------------
  // configuration
  // --------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      cfg_reg      <= `CRX_CFG_RST;
      fext_reg     <= 16'h0000;
      fassign_reg  <= 16'h0000;
      fassign2_reg <= 16'h0000;
      txcfg_reg    <= 2'b00;
    end
    else if (wb_wr)
    begin
      case (i_wb_adr)
        `CRX_OFF_CFG:      cfg_reg      <= {20'h0, i_wb_dat[11:0]};
        `CRX_OFF_FEXT:     fext_reg     <= i_wb_dat[15:0];
        `CRX_OFF_FASSIGN:  fassign_reg  <= i_wb_dat[15:0];
        `CRX_OFF_FASSIGN2: fassign2_reg <= i_wb_dat[15:0];
        `CRX_OFF_TXCFG:    txcfg_reg    <= i_wb_dat[1:0];
        default:           txcfg_reg    <= txcfg_reg;
      endcase
    end
  end

  // --------------------------------------------------------------
  // stored frames
  // --------------------------------------------------------------
  // content stays until the next load into the same buffer; a full buffer
  // is never loaded, which is what locks it against overwrite
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      rtr_reg <= 2'b00;
      ext_reg <= 2'b00;
      for (k = 0; k < 2; k = k + 1)
      begin
        hit_reg[k]  <= 5'h00;
        dlc_reg[k]  <= 4'h0;
        id_reg[k]   <= 29'h0;
        data_reg[k] <= 64'h0;
      end
    end
    else
    begin
      for (k = 0; k < 2; k = k + 1)
      begin
        if (load[k])
        begin
          rtr_reg[k]  <= i_frame_rtr;
          ext_reg[k]  <= i_frame_ext;
          id_reg[k]   <= id_store;
          hit_reg[k]  <= (k == 0) ? hit_store0 : hit_store1;
          dlc_reg[k]  <= i_frame_dlc;
          data_reg[k] <= i_frame_data;
        end
      end
    end
  end

  // --------------------------------------------------------------
  // full and overflow flags
  // --------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      full_reg <= 2'b00;
      ovf_reg  <= 1'b0;
    end
    else
    begin
      full_reg <= load | (full_reg & ~full_clr);
      if (ovf_evt)
        ovf_reg <= 1'b1;
      else if (ovf_clr)
        ovf_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // status outputs
  // --------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_rx_irq      <= 1'b0;
      o_rx_overflow <= 1'b0;
    end
    else
    begin
      // one pulse per load; the assembly side never waits on it
      o_rx_irq      <= cfg_reg[`CRX_CFG_RIE] && (load != 2'b00);
      o_rx_overflow <= ovf_evt || (ovf_reg && !ovf_clr);
    end
  end

endmodule
`default_nettype wire

// ### bench/crx_rx_chk.sv
/*
 port checker for crx_rx_buffers, bound to every instance.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module crx_rx_chk
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // watched ports
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  input wire logic i_frame_done,
  input wire logic o_rx_irq,
  input wire logic o_rx_overflow
);
  // ------------------------------------------------------------
  // bus and status relations
  // ------------------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_rst; $past(i_sys_rst) |-> !o_rx_irq && !o_wb_ack && !o_rx_overflow; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_ack_req; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
  a_ack_req: assert property (p_ack_req) else $error("bus request not acked next cycle");
  property p_ack_one; o_wb_ack |=> !o_wb_ack; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_ack_cause; o_wb_ack |-> $past(i_wb_cyc && i_wb_stb); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_irq_cause; o_rx_irq |-> $past(i_frame_done); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without frame");
  property p_irq_one; o_rx_irq && !i_frame_done |=> !o_rx_irq; endproperty
  a_irq_one: assert property (p_irq_one) else $error("irq pulse too long");
  // the copy is loaded in the same cycle as the sticky flag, so the cause is one cycle back
  property p_ovf_rise; $rose(o_rx_overflow) |-> $past(i_frame_done) || $past(i_frame_done, 2);
  endproperty
  a_ovf_rise: assert property (p_ovf_rise) else $error("overflow without frame");
  property p_ovf_hold; o_rx_overflow && !i_wb_cyc && !$past(i_wb_cyc) |=> o_rx_overflow;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow lost");
endmodule
bind crx_rx_buffers crx_rx_chk u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack),
  .i_frame_done(i_frame_done), .o_rx_irq(o_rx_irq), .o_rx_overflow(o_rx_overflow));
`default_nettype wire

// ### bench/crx_eng_model.sv
/*
 protocol engine model: presents assembled frames as one-cycle pulses.
 assumes the caller paces frames; it never waits on the buffers.
*/
`timescale 1ns/1ns
`default_nettype none
module crx_eng_model
(
  // clock
  input  wire logic        i_clk,
  // assembled frame
  output var  logic        o_done = 1'b0,
  output var  logic        o_err = 1'b0,
  output var  logic        o_ext = 1'b0,
  output var  logic        o_rtr = 1'b0,
  output var  logic [28:0] o_id = 29'h0,
  output var  logic [3:0]  o_dlc = 4'h0,
  output var  logic [63:0] o_data = 64'h0,
  output var  logic [15:0] o_match = 16'h0
);
  // ------------------------------------------------------------
  // frame hand-off
  // ------------------------------------------------------------
  task send(input logic e, r, x, input logic [28:0] id, input logic [3:0] dl,
            input logic [63:0] d, input logic [15:0] m);
    @(posedge i_clk);
    o_done <= 1'b1;
    o_err <= x;
    o_ext <= e;
    o_rtr <= r;
    o_id <= id;
    o_dlc <= dl;
    o_data <= d;
    o_match <= m;
    @(posedge i_clk);
    // fields are invalid once done drops, so show the inverse of all but rtr and dlc, not stale data
    o_done <= 1'b0;
    o_err <= ~x;
    o_ext <= ~e;
    o_id <= ~id;
    o_data <= ~d;
    o_match <= ~m;
  endtask
endmodule
`default_nettype wire

// ### bench/crx_rx_buffers_tb.sv
/*
 bench for crx_rx_buffers in mode 0, checked against a reference model, and in mode 1 (opmode 01) for the modes 1/2 logic.
 assumes the engine model supplies frames; wishbone is driven here.
*/
`timescale 1ns/1ns
`default_nettype none
module crx_rx_buffers_tb;
  // ------------------------------------------------------------
  // stimulus, reference model and checks
  // ------------------------------------------------------------
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic [1:0] receive_mode_select [2];
  logic [15:0] fx;
  wire [31:0] wb_dat;
  wire ack, irq, ovf_o, done, err, ext, rtr;
  wire [28:0] id;
  wire [3:0] dlc;
  wire [63:0] dat;
  wire [15:0] mat;
  integer seed = 32'heace3abe, error_cnt = 0, samples_checked = 0, fl[2], ovf, roll, r;
  crx_eng_model eng (.i_clk(clk), .o_done(done), .o_err(err), .o_ext(ext), .o_rtr(rtr),
    .o_id(id), .o_dlc(dlc), .o_data(dat), .o_match(mat));
  crx_rx_buffers dut (.i_clk(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wd), .o_wb_dat(wb_dat),
    .o_wb_ack(ack), .i_frame_done(done), .i_frame_err(err), .i_frame_ext(ext),
    .i_frame_rtr(rtr), .i_frame_id(id), .i_frame_dlc(dlc), .i_frame_data(dat),
    .i_filter_match(mat), .o_rx_irq(irq), .o_rx_overflow(ovf_o));
  initial forever #20 clk = ~clk;
  task chk(input logic [31:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    n = 0;
    do @(posedge clk); while (ack !== 1'b1 && ++n < 20);
    rd = wb_dat;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    if (n >= 20) error_cnt++;
  endtask
  task clr;
    wb(1, 8'h04, 32'h7);
    fl[0] = 0;
    fl[1] = 0;
    ovf = 0;
  endtask
  task cfgw;
    wb(1, 8'h00, {24'h0, receive_mode_select[1], receive_mode_select[0], roll[0], 3'b100});
  endtask
  // hit 16 means accepted with no filter index to compare
  function integer acc(integer b, e, x, logic [15:0] m);
    integer f;
    acc = -1;
    if (receive_mode_select[b] == 3) return 16;
    if (x || (receive_mode_select[b] == 1 && e) || (receive_mode_select[b] == 2 && !e)) return -1;
    for (f = 2 * b; f <= 1 + 4 * b; f++)
      if (acc < 0 && m[f] && fx[f] == e) acc = f;
  endfunction
  task frm(input integer e, rr, x, input logic [15:0] m);
    integer a0, a1, d, h, dl;
    logic [28:0] i;
    logic [63:0] v;
    i = $random(seed);
    if (!e) i[28:11] = 0;
    v = {$random(seed), $random(seed)};
    dl = {$random(seed)} % 9;
    a0 = acc(0, e, x, m);
    a1 = acc(1, e, x, m);
    d = -1;
    h = 16;
    if (a0 >= 0 && !fl[0])
    begin
      d = 0;
      h = a0;
    end
    else if (a0 >= 0 && roll && !fl[1]) d = 1;
    else if (a1 >= 0 && !fl[1])
    begin
      d = 1;
      h = a1;
    end
    else if (a0 >= 0 || a1 >= 0) ovf = 1;
    eng.send(e[0], rr[0], x[0], i, dl[3:0], v, m);
    #1;
    chk(irq, d >= 0);
    if (d >= 0) fl[d] = 1;
    wb(0, 8'h04, 0);
    chk(rd[2:0], {ovf[0], fl[1][0], fl[0][0]});
    chk(ovf_o, ovf);
    if (d < 0) return;
    wb(0, 8'(8 + 4 * d), 0);
    chk(rd[2:0], {e[0], rr[0], 1'b1});
    chk(rd[19:16], dl);
    if (h < 16) chk(rd[12:8], h);
    wb(0, 8'(16 + 4 * d), 0);
    chk(rd[28:0], i);
    if (d > 0 || dl < 4) return;
    wb(0, 8'h18, 0);
    chk(rd, v[31:0]);
  endtask
  // modes 1/2: one standard frame per call, expected buffer d (-1 none), hit h
  task m1(input logic [31:0] c, input logic [15:0] m, input integer d, h);
    wb(1, 8'h00, c);
    eng.send(1'b0, 1'b0, 1'b0, 29'h0000_07A5, 4'h2, 64'h0, m);
    #1;
    chk(irq, d >= 0);
    wb(0, 8'h04, 0);
    chk(rd[2:0], d < 0 ? 3'h0 : 3'(1 << d));
    if (d >= 0)
    begin
      wb(0, 8'(8 + 4 * d), 0);
      chk(rd[12:8], h);
    end
    clr;
  endtask
  task results;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results;
  end
  initial
  begin
    fl[0] = 0;
    fl[1] = 0;
    ovf = 0;
    roll = 0;
    receive_mode_select[0] = 0;
    receive_mode_select[1] = 0;
    fx = 16'h0032;
    repeat (3) @(posedge clk);
    rst <= 0;
    for (r = 0; r < 16; r += 4)
    begin
      wb(0, 8'(r == 12 ? 60 : r), 0);
      if (r < 12 || r == 12) chk(rd, 0);
    end
    wb(1, 8'h28, {16'h0, fx});
    cfgw;
    $display("test reset done");
    frm(0, 0, 0, 16'h0001);
    frm(0, 1, 0, 16'h0001);
    frm(1, 0, 0, 16'h0010);
    clr;
    frm(0, 0, 0, 16'h0005);
    roll = 1;
    cfgw;
    frm(0, 1, 0, 16'h0001);
    frm(0, 0, 0, 16'h0001);
    clr;
    roll = 0;
    $display("test priority done");
    for (r = 0; r < 4; r++)
    begin
      receive_mode_select[0] = r[1:0];
      cfgw;
      frm(1, 0, 0, 16'h0002);
      clr;
      frm(0, 0, 0, 16'h0001);
      clr;
      frm(0, 1, 1, 16'h0000);
      clr;
    end
    $display("test modes done");
    receive_mode_select[0] = 0;
    cfgw;
    repeat (12)
    begin
      frm({$random(seed)} % 2, {$random(seed)} % 2, 0, $random(seed));
      if (fl[0] && fl[1]) clr;
    end
    $display("test random done");
    wb(1, 8'h2C, 32'h0000_0100);
    wb(1, 8'h30, 32'h0000_0101);
    m1(32'h0000_0005, 16'h0101, 0, 0);
    m1(32'h0000_0005, 16'h0100, 1, 8);
    wb(1, 8'h34, 32'h0000_0002);
    m1(32'h0000_0005, 16'h0100, -1, 0);
    m1(32'h0000_0415, 16'h0001, -1, 0);
    m1(32'h0000_0015, 16'h0001, 0, 0);
    m1(32'h0000_0025, 16'h0000, 0, 0);
    $display("test modes 1/2 done");
    results;
  end
endmodule
`default_nettype wire
